// *** pdwl_pkg.sv ***
// Constants and types shared by the peripheral-disable write-lock logic.
package pdwl_pkg;

  // ==========================================================================
  // Register layout
  // ==========================================================================
  localparam int          PD_COUNT      = 4;              // Peripheral-disable registers.
  localparam int          PD_SEL_W      = 2;              // Width of the register select.
  localparam int          DATA_W        = 32;             // Word width of every register.
  localparam int          LOCK_BIT      = 12;             // Lock bit in system_config_reg.
  localparam int          ONE_SHOT_BIT  = 28;             // One-shot bit in config word three.
  localparam logic        LOCK_RESET    = 1'b1;           // Lock is engaged after reset.
  localparam logic [31:0] PD_RESET      = 32'h0000_0000;  // Peripheral-disable reset value.

  // ==========================================================================
  // Unlock keys (arbitrary values, not tied to any real part)
  // ==========================================================================
  localparam logic [31:0] UNLOCK_KEY1   = 32'h5a5a_c3c3;
  localparam logic [31:0] UNLOCK_KEY2   = 32'ha5a5_3c3c;

  // ==========================================================================
  // Unlock sequence states
  // ==========================================================================
  typedef enum logic [1:0] {
    PDWL_LOCKED   = 2'b00,
    PDWL_KEY1_OK  = 2'b01,
    PDWL_UNLOCKED = 2'b10
  } pdwl_unlock_state_t;

endpackage

// *** pdwl_top.sv ***
// Write lock guarding the peripheral-disable registers, with one-shot option.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R01 - Peripheral-disable writes rejected while lock set.
// R02 - Rejected writes complete silently, contents unchanged.
// R03 - Lock bit twelve of config: set blocks.
// R04 - Lock bit changes only after unlock sequence.
// R05 - One-shot setting: lock cannot clear once software sets it.
// R06 - One-shot lock held: no unlock, writes blocked.
// R07 - Only reset clears a one-shot latched lock.
// R08 - Reset restores lock and re-arms one-shot latch.
module pdwl_top
(
  // Clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  reset,
  // Device configuration word three, sampled while reset is held
  input  wire logic [31:0]                           device_config_word_three,
  // Unlock key writes
  input  wire logic                                  key_wr,
  input  wire logic [31:0]                           key_data,
  // System configuration register writes
  input  wire logic                                  cfg_wr,
  input  wire logic [31:0]                           cfg_wdata,
  // Peripheral-disable register writes
  input  wire logic                                  pd_wr,
  input  wire logic [pdwl_pkg::PD_SEL_W-1:0]         pd_sel,
  input  wire logic [31:0]                           pd_wdata,
  // Register contents and status
  output logic [pdwl_pkg::PD_COUNT-1:0][31:0]        peripheral_disable_regs,
  output logic                                       disable_write_lock,
  output logic                                       lock_frozen,
  output logic                                       unlocked,
  output logic                                       wr_done
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic                                     lock_reg;
  logic                                     lock_next;
  logic                                     latched_reg;
  logic                                     latched_next;
  logic                                     one_shot_reg;
  logic                                     frozen;
  logic                                     frozen_reg;
  logic                                     frozen_next;
  logic                                     lock_change_ok;
  logic                                     wr_done_reg;
  logic                                     wr_done_next;
  logic [pdwl_pkg::PD_COUNT-1:0][31:0]      pd_regs_reg;
  logic [pdwl_pkg::PD_COUNT-1:0][31:0]      pd_regs_next;

  // ==========================================================================
  // Unlock sequence
  // ==========================================================================
  // The detector is held shut while the one-shot lock is frozen.
  pdwl_unlock_seq u_unlock
  (
    .clk      (clk),
    .reset    (reset),
    .key_wr   (key_wr),
    .key_data (key_data),
    .inhibit  (frozen),                                  // R06
    .unlocked (unlocked)
  );

  // ==========================================================================
  // Lock bit and one-shot latch
  // ==========================================================================
  // Frozen once the one-shot setting is on and software has set the lock.
  // The flag is a flop fed from the next values, so the status pin is glitch
  // free yet rises in the same cycle as the lock and latch bits.
  assign frozen = frozen_reg;

  // The same-cycle frozen check closes the one cycle in which the detector
  // still reports an open session after the latch takes hold.
  always_comb
  begin
    lock_change_ok = cfg_wr & unlocked & ~frozen;         // R04
    lock_next      = lock_reg;
    latched_next   = latched_reg;
    if (lock_change_ok)
    begin
      lock_next    = cfg_wdata[pdwl_pkg::LOCK_BIT];       // R03
      latched_next = latched_reg | cfg_wdata[pdwl_pkg::LOCK_BIT];
    end
    frozen_next    = one_shot_reg & latched_next & lock_next;  // R05
  end

  // The one-shot strap is caught while reset is held, so a change on the
  // configuration word during operation has no effect until the next reset.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lock_reg     <= pdwl_pkg::LOCK_RESET;               // R07
      latched_reg  <= 1'b0;                               // R08
      frozen_reg   <= 1'b0;                               // R08
      one_shot_reg <= device_config_word_three[pdwl_pkg::ONE_SHOT_BIT];
    end
    else
    begin
      lock_reg     <= lock_next;
      latched_reg  <= latched_next;
      one_shot_reg <= one_shot_reg;
      frozen_reg   <= frozen_next;
    end
  end

  // ==========================================================================
  // Peripheral-disable registers
  // ==========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < pdwl_pkg::PD_COUNT; gi++)
    begin : g_pd
      // A write lands only when the lock is open; otherwise it is dropped.
      always_comb
      begin
        pd_regs_next[gi] = pd_regs_reg[gi];
        if (pd_wr && !lock_reg && (pd_sel == pdwl_pkg::PD_SEL_W'(gi)))  // R01
        begin
          pd_regs_next[gi] = pd_wdata;                    // R03
        end
      end

      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          pd_regs_reg[gi] <= pdwl_pkg::PD_RESET;
        end
        else
        begin
          pd_regs_reg[gi] <= pd_regs_next[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Write completion
  // ==========================================================================
  // Every peripheral-disable or config write completes the same way whether accepted
  // or not, so software sees no difference on the bus side.
  always_comb
  begin
    wr_done_next = pd_wr | cfg_wr;                        // R02
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_done_reg <= 1'b0;
    end
    else
    begin
      wr_done_reg <= wr_done_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign peripheral_disable_regs = pd_regs_reg;
  assign disable_write_lock      = lock_reg;
  assign lock_frozen             = frozen;
  assign wr_done                 = wr_done_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_key_pair;
    (key_wr && key_data == pdwl_pkg::UNLOCK_KEY1 && !frozen)
    ##1 (key_wr && key_data == pdwl_pkg::UNLOCK_KEY2 && !frozen);
  endsequence

  sequence s_open_write;
    cfg_wr && unlocked && !frozen;
  endsequence

  pd_blocked_a: assert property (lock_reg && pd_wr |=> $stable(pd_regs_reg)) // R01
    else $error("Peripheral-disable register changed while locked.");

  pd_accept_a: assert property (!lock_reg && pd_wr |=>            // R03
    pd_regs_reg[$past(pd_sel)] == $past(pd_wdata))
    else $error("Unlocked peripheral-disable write was not stored.");

  wr_done_a: assert property ((pd_wr || cfg_wr) |=> wr_done) // R02
    else $error("Write did not complete.");

  wr_quiet_a: assert property (!(pd_wr || cfg_wr) |=> !wr_done) // R02
    else $error("Completion pulsed without a write.");

  lock_nokey_a: assert property (cfg_wr && !unlocked |=> $stable(lock_reg)) // R04
    else $error("Lock bit changed without an unlock session.");

  lock_key_a: assert property (s_open_write |=>                   // R04
    lock_reg == $past(cfg_wdata[pdwl_pkg::LOCK_BIT]))
    else $error("Lock bit did not follow an unlocked write.");

  seq_opens_a: assert property (s_key_pair |=> unlocked)          // R04
    else $error("Key pair did not open a session.");

  one_way_a: assert property (frozen |=> lock_reg && frozen [*2]) // R05
    else $error("One-shot lock was released.");

  no_unlock_a: assert property (frozen |=> !unlocked)             // R06
    else $error("Unlock ran while one-shot lock held.");

  gate_refused_a: assert property (cfg_wr && frozen |=> lock_reg) // R05
    else $error("Config write changed a frozen lock.");

  frozen_state_a: assert property (frozen |-> lock_reg && one_shot_reg) // R05
    else $error("Frozen flag disagrees with lock state.");

  reset_rearm_a: assert property (disable iff (1'b0)              // R08
    reset |=> lock_reg && !latched_reg && !unlocked && !frozen)
    else $error("Reset did not restore the lock state.");

endmodule
`default_nettype wire

// *** pdwl_top_tb.sv ***
// Self-checking testbench for the peripheral-disable write lock.
`timescale 1ns/1ps
`default_nettype none

module pdwl_top_tb;

  // ==========================================================================
  // Signals and instance
  // ==========================================================================
  logic                                       clk;
  logic                                       reset;
  logic [31:0]                                cfg3;
  logic                                       key_wr;
  logic [31:0]                                key_data;
  logic                                       cfg_wr;
  logic [31:0]                                cfg_wdata;
  logic                                       pd_wr;
  logic [pdwl_pkg::PD_SEL_W-1:0]              pd_sel;
  logic [31:0]                                pd_wdata;
  logic [pdwl_pkg::PD_COUNT-1:0][31:0]        pd_regs;
  logic                                       lock;
  logic                                       frozen;
  logic                                       unlocked;
  logic                                       wr_done;
  int                                         bad_count;
  int                                         total_checks;
  int                                         cycles;

  pdwl_top u_pdwl_top (
    .clk                      (clk),
    .reset                    (reset),
    .device_config_word_three (cfg3),
    .key_wr                   (key_wr),
    .key_data                 (key_data),
    .cfg_wr                   (cfg_wr),
    .cfg_wdata                (cfg_wdata),
    .pd_wr                    (pd_wr),
    .pd_sel                   (pd_sel),
    .pd_wdata                 (pd_wdata),
    .peripheral_disable_regs  (pd_regs),
    .disable_write_lock       (lock),
    .lock_frozen              (frozen),
    .unlocked                 (unlocked),
    .wr_done                  (wr_done)
  );

  // Case equality keeps an unknown output from passing as a match.
  `define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

  // ==========================================================================
  // Clock, watchdog and verdict
  // ==========================================================================
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The whole run needs under a hundred cycles; the ceiling leaves ample margin.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Drivers, all changing inputs at the falling edge
  // ==========================================================================
  task automatic do_reset(input logic one_shot);
    reset = 1'b1;
    cfg3  = {3'h0, one_shot, 28'h0};
    repeat (3) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    `CHK("reset lock", pdwl_pkg::LOCK_RESET, lock)
    `CHK("reset frozen", 1'b0, frozen)
    `CHK("reset unlocked", 1'b0, unlocked)
    for (int i = 0; i < pdwl_pkg::PD_COUNT; i++)
      `CHK("reset pd", pdwl_pkg::PD_RESET, pd_regs[i])
  endtask

  task automatic send_keys(input logic exp_open);
    key_wr   = 1'b1;
    key_data = pdwl_pkg::UNLOCK_KEY1;
    @(negedge clk);
    key_data = pdwl_pkg::UNLOCK_KEY2;
    @(negedge clk);
    key_wr   = 1'b0;
    `CHK("session", exp_open, unlocked)
  endtask

  // A write of either kind; wr_done must pulse once whether taken or refused.
  task automatic wr(input logic is_cfg, input logic [1:0] sel, input logic [31:0] d);
    cfg_wr    = is_cfg;
    pd_wr     = ~is_cfg;
    cfg_wdata = d;
    pd_sel    = sel;
    pd_wdata  = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    pd_wr  = 1'b0;
    `CHK("wr_done high", 1'b1, wr_done)
    @(negedge clk);
    `CHK("wr_done low", 1'b0, wr_done)
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_locked_rejects();
    wr(1'b0, 2'h1, 32'hdead_beef);
    `CHK("locked pd", pdwl_pkg::PD_RESET, pd_regs[1])
    wr(1'b1, 2'h0, 32'h0000_0000);
    `CHK("cfg no keys", 1'b1, lock)
    // A stray value between the two keys must restart the pattern.
    key_wr   = 1'b1;
    key_data = pdwl_pkg::UNLOCK_KEY1;
    @(negedge clk);
    key_data = 32'h0000_0000;
    @(negedge clk);
    key_data = pdwl_pkg::UNLOCK_KEY2;
    @(negedge clk);
    key_wr = 1'b0;
    `CHK("bad key order", 1'b0, unlocked)
  endtask

  task automatic t_session(input logic [31:0] d);
    send_keys(1'b1);
    wr(1'b1, 2'h0, 32'h0000_0000);
    `CHK("lock cleared", 1'b0, lock)
    wr(1'b0, 2'h3, d);
    `CHK("pd stored", d, pd_regs[3])
    wr(1'b0, 2'h0, ~d);
    `CHK("pd stored 0", ~d, pd_regs[0])
    wr(1'b1, 2'h0, 32'h0000_1000);
    `CHK("lock set", 1'b1, lock)
    wr(1'b0, 2'h3, 32'h0123_4567);
    `CHK("pd blocked", d, pd_regs[3])
  endtask

  task automatic t_one_shot();
    t_session(32'h1357_9bdf);
    @(negedge clk);
    `CHK("frozen", 1'b1, frozen)
    `CHK("session ended", 1'b0, unlocked)
    send_keys(1'b0);
    wr(1'b1, 2'h0, 32'h0000_0000);
    `CHK("frozen lock", 1'b1, lock)
    wr(1'b0, 2'h3, 32'hffff_ffff);
    `CHK("frozen pd", 32'h1357_9bdf, pd_regs[3])
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    bad_count = 0;
    total_checks = 0;
    cycles = 0;
    key_wr = 1'b0;
    key_data = 32'h0;
    cfg_wr = 1'b0;
    cfg_wdata = 32'h0;
    pd_wr = 1'b0;
    pd_sel = 2'h0;
    pd_wdata = 32'h0;
    do_reset(1'b0);
    t_locked_rejects();
    t_session(32'h00a5_5a00);
    // Without the one-shot setting a second session must still open.
    send_keys(1'b1);
    wr(1'b1, 2'h0, 32'h0000_0000);
    `CHK("second clear", 1'b0, lock)
    `CHK("not frozen", 1'b0, frozen)
    do_reset(1'b1);
    t_one_shot();
    // Only reset lifts the frozen lock and allows a fresh session.
    do_reset(1'b1);
    t_session(32'h0f0f_f0f0);
    report_and_stop();
  end

  `undef CHK

endmodule

`default_nettype wire

// *** pdwl_unlock_seq.sv ***
// Two-key unlock sequence detector that opens a lock-bit write session.
`timescale 1ns/1ps
`default_nettype none

module pdwl_unlock_seq
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Key writes
  input  wire logic        key_wr,
  input  wire logic [31:0] key_data,
  // Suppression from the one-shot lock
  input  wire logic        inhibit,
  // Session state
  output logic             unlocked
);

  // ==========================================================================
  // Sequence state
  // ==========================================================================
  pdwl_pkg::pdwl_unlock_state_t state_reg;
  pdwl_pkg::pdwl_unlock_state_t state_next;
  logic                         unlocked_next;

  // Any key write that breaks the pattern drops back to locked, or to PDWL_KEY1_OK
  // if it carries the first key, so a stray write cannot leave a half-open session behind.
  always_comb
  begin
    state_next = state_reg;
    if (inhibit)
    begin
      state_next = pdwl_pkg::PDWL_LOCKED;
    end
    else if (key_wr)
    begin
      case (state_reg)
        pdwl_pkg::PDWL_KEY1_OK:
          state_next = (key_data == pdwl_pkg::UNLOCK_KEY2) ? pdwl_pkg::PDWL_UNLOCKED :
                       (key_data == pdwl_pkg::UNLOCK_KEY1) ? pdwl_pkg::PDWL_KEY1_OK :
                       pdwl_pkg::PDWL_LOCKED;
        default:
          state_next = (key_data == pdwl_pkg::UNLOCK_KEY1) ? pdwl_pkg::PDWL_KEY1_OK :
                       pdwl_pkg::PDWL_LOCKED;
      endcase
    end
    unlocked_next = (state_next == pdwl_pkg::PDWL_UNLOCKED);
  end

  // The session flag is registered from the next state so it stays a flop.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= pdwl_pkg::PDWL_LOCKED;
      unlocked  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      unlocked  <= unlocked_next;
    end
  end

endmodule
`default_nettype wire
